// *** wdt_pkg.sv ***
// Constants shared by the watchdog timeout control block: register offsets,
// field positions, reset values and time base figures.
// Assumes a 125 MHz system clock and a 32-bit classic Wishbone slave port.
package wdt_pkg;

    // System clock and watchdog time base
    localparam int unsigned CLK_HZ        = 125000000;
    localparam int unsigned TICK_HZ       = 32;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / TICK_HZ;
    localparam int unsigned TICK_W        = 22;

    // Bus geometry
    localparam int unsigned ADR_W         = 8;
    localparam int unsigned DAT_W         = 32;
    localparam int unsigned SEL_W         = 4;

    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL    = 8'h00;
    localparam logic [7:0] OFS_STATUS     = 8'h04;
    localparam logic [7:0] OFS_INT_STAT   = 8'h08;
    localparam logic [7:0] OFS_INT_MASK   = 8'h0C;

    // watchdog_control fields
    localparam int unsigned TOUT_W        = 6;
    localparam int unsigned TOUT_LSB      = 0;
    localparam int unsigned LOCK_BIT      = 6;
    localparam int unsigned STROBE_BIT    = 7;

    // Status fields
    localparam int unsigned RUN_BIT       = 0;
    localparam int unsigned COUNT_LSB     = 8;

    // Interrupt status and mask fields
    localparam int unsigned EXPIRE_BIT    = 0;

    // Reset values
    localparam logic [5:0] TOUT_RST       = 6'h00;
    localparam logic       LOCK_RST       = 1'b0;
    localparam logic       MASK_RST       = 1'b0;

endpackage

// *** wdt_ctrl_if.sv ***
// Carrier between the register front end and the watchdog counter.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface wdt_ctrl_if;
    import wdt_pkg::*;

    logic [TOUT_W-1:0] timeout_select;   // Programmed interval in ticks
    logic              restart;          // Reload and start a fresh interval
    logic              tick;             // One cycle per 32 Hz period
    logic              expire;           // One cycle at end of interval
    logic [TOUT_W-1:0] count;            // Ticks left in current interval

    modport regs  (output timeout_select, output restart, input tick,
                   input expire, input count);
    modport timer (input timeout_select, input restart, input tick,
                   output expire, output count);
endinterface
`default_nettype wire

// *** wdt_tick.sv ***
// 32 Hz time base divider for the watchdog.
// Assumes restart is a single cycle request from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module wdt_tick #(
    parameter int unsigned TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    input  wire logic               restart_in,
    output logic                    tick_out
);
    import wdt_pkg::*;

    localparam logic [TICK_W-1:0] LAST = TICK_W'(TICK_CYCLES - 1);

    logic [TICK_W-1:0] div_r;

    // Divider restarts with the watchdog so every interval is whole ticks
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_r    <= '0;
            tick_out <= 1'b0;
        end else if (restart_in) begin
            div_r    <= '0;
            tick_out <= 1'b0;
        end else if (div_r == LAST) begin
            div_r    <= '0;
            tick_out <= 1'b1;
        end else begin
            div_r    <= div_r + TICK_W'(1);
            tick_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** wdt_counter.sv ***
// Watchdog interval counter: counts 32 Hz ticks down from the timeout.
// Assumes tick and restart come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module wdt_counter (
    input  wire logic clk_in,
    input  wire logic rst_in,
    wdt_ctrl_if.timer ctl
);
    import wdt_pkg::*;

    logic [TOUT_W-1:0] count_r;
    logic              expire_r;
    logic              enabled;

    // Zero timeout keeps the timer idle
    assign enabled = (ctl.timeout_select != '0);

    // Countdown; reload on restart or at the end of each interval
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_r <= '0;
        end else if (!enabled) begin
            count_r <= '0;
        end else if (ctl.restart) begin
            count_r <= ctl.timeout_select;
        end else if (ctl.tick) begin
            if (count_r <= TOUT_W'(1)) begin
                count_r <= ctl.timeout_select;
            end else begin
                count_r <= count_r - TOUT_W'(1);
            end
        end
    end

    // Expiry pulse on the tick that empties the count
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            expire_r <= 1'b0;
        end else begin
            expire_r <= enabled && !ctl.restart && ctl.tick && (count_r == TOUT_W'(1));
        end
    end

    assign ctl.count  = count_r;
    assign ctl.expire = expire_r;
endmodule
`default_nettype wire

// *** wdt_timeout_ctrl.sv ***
// Watchdog timeout control: control register, strobe, lock, interrupt logic
// and a classic Wishbone slave port.
// Assumes a single 125 MHz clock and bus signals from logic on that clock.
`timescale 1ns/1ps
`default_nettype none
module wdt_timeout_ctrl #(
    parameter int unsigned TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
    input  wire logic                          MCLK_IN,
    input  wire logic                          SYS_RST_IN,
    input  wire logic                          WB_CYC_IN,
    input  wire logic                          WB_STB_IN,
    input  wire logic                          WB_WE_IN,
    input  wire logic [wdt_pkg::ADR_W-1:0]     WB_ADR_IN,
    input  wire logic [wdt_pkg::SEL_W-1:0]     WB_SEL_IN,
    input  wire logic [wdt_pkg::DAT_W-1:0]     WB_DAT_IN,
    output logic      [wdt_pkg::DAT_W-1:0]     WB_DAT_OUT,
    output logic                               WB_ACK_OUT,
    output logic                               IRQ_OUT,
    output logic                               WDT_EXPIRE_OUT
);
    import wdt_pkg::*;

    // Bus access decode
    logic                 access;
    logic                 wr_en;
    logic                 wr_lane0;
    logic                 hit_control;
    logic                 hit_status;
    logic                 hit_int_stat;
    logic                 hit_int_mask;

    // Register state
    logic [TOUT_W-1:0]    timeout_select_r;
    logic                 timeout_write_lock_r;
    logic                 watchdog_strobe_r;
    logic                 int_stat_r;
    logic                 int_mask_r;
    logic                 ack_r;
    logic [DAT_W-1:0]     dat_r;
    logic [DAT_W-1:0]     dat_nxt;
    logic                 irq_r;
    logic                 expire_r;

    // Timeout write qualifiers
    logic                 ctl_write;
    logic                 tout_accept;
    logic                 strobe_write;

    // Interrupt register write qualifiers
    logic                 stat_write;
    logic                 mask_write;
    logic                 expire_clear;

    // Read words of each register before the address mux
    logic [DAT_W-1:0]     rd_control;
    logic [DAT_W-1:0]     rd_status;
    logic [DAT_W-1:0]     rd_int_stat;
    logic [DAT_W-1:0]     rd_int_mask;

    wdt_ctrl_if ctl ();

    // A request is served once; ack drops in the cycle after it was given
    assign access       = WB_CYC_IN && WB_STB_IN && !ack_r;
    assign wr_en        = access && WB_WE_IN;
    assign wr_lane0     = WB_SEL_IN[0];
    assign hit_control  = (WB_ADR_IN == OFS_CONTROL);
    assign hit_status   = (WB_ADR_IN == OFS_STATUS);
    assign hit_int_stat = (WB_ADR_IN == OFS_INT_STAT);
    assign hit_int_mask = (WB_ADR_IN == OFS_INT_MASK);

    // Control writes split into strobe and timeout parts
    assign ctl_write    = wr_en && hit_control && wr_lane0;
    assign strobe_write = ctl_write && WB_DAT_IN[STROBE_BIT];
    assign tout_accept  = ctl_write && !WB_DAT_IN[LOCK_BIT]
                          && !timeout_write_lock_r;

    // Interrupt register writes; all their fields sit in the low byte
    assign stat_write   = wr_en && hit_int_stat && wr_lane0;
    assign mask_write   = wr_en && hit_int_mask && wr_lane0;
    assign expire_clear = stat_write && WB_DAT_IN[EXPIRE_BIT];

    // Acknowledge every addressed cycle, mapped or not, one cycle later
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= access;
        end
    end

    // Lock bit follows every control write that enables byte lane 0
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            timeout_write_lock_r <= LOCK_RST;
        end else if (ctl_write) begin
            timeout_write_lock_r <= WB_DAT_IN[LOCK_BIT];
        end
    end

    // Timeout selection, guarded by the lock from the previous write
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            timeout_select_r <= TOUT_RST;
        end else if (tout_accept) begin
            timeout_select_r <= WB_DAT_IN[TOUT_LSB +: TOUT_W];
        end
    end

    // Strobe is raised by software or by a new timeout, cleared after restart
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            watchdog_strobe_r <= 1'b0;
        end else if (strobe_write || tout_accept) begin
            watchdog_strobe_r <= 1'b1;
        end else if (watchdog_strobe_r) begin
            watchdog_strobe_r <= 1'b0;
        end
    end

    // Hand the programmed interval to the counter
    assign ctl.timeout_select = timeout_select_r;
    assign ctl.restart        = watchdog_strobe_r;

    // 32 Hz time base; each tick is one unit of timeout
    wdt_tick #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_in      (MCLK_IN),
        .rst_in      (SYS_RST_IN),
        .restart_in  (watchdog_strobe_r),
        .tick_out    (ctl.tick)
    );

    // Interval counter; idles while the timeout is zero
    wdt_counter u_counter (
        .clk_in  (MCLK_IN),
        .rst_in  (SYS_RST_IN),
        .ctl     (ctl)
    );

    // Expiry sticky bit: a new expiry wins over a write-one clear
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            int_stat_r <= 1'b0;
        end else if (ctl.expire) begin
            int_stat_r <= 1'b1;
        end else if (expire_clear) begin
            int_stat_r <= 1'b0;
        end
    end

    // Interrupt mask
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            int_mask_r <= MASK_RST;
        end else if (mask_write) begin
            int_mask_r <= WB_DAT_IN[EXPIRE_BIT];
        end
    end

    // Level interrupt, high while the unmasked expiry bit is set
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= int_stat_r && int_mask_r;
        end
    end

    // Expiry pulse retimed so the top output comes from a flip-flop
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            expire_r <= 1'b0;
        end else begin
            expire_r <= ctl.expire;
        end
    end

    // Control reads back timeout and lock; the strobe position is always zero
    always_comb begin
        rd_control                     = '0;
        rd_control[TOUT_LSB +: TOUT_W] = timeout_select_r;
        rd_control[LOCK_BIT]           = timeout_write_lock_r;
        rd_control[STROBE_BIT]         = 1'b0;
    end

    // Status shows whether the timer runs and how many ticks are left
    always_comb begin
        rd_status                      = '0;
        rd_status[RUN_BIT]             = (timeout_select_r != '0);
        rd_status[COUNT_LSB +: TOUT_W] = ctl.count;
    end

    // Interrupt status and mask words
    always_comb begin
        rd_int_stat             = '0;
        rd_int_stat[EXPIRE_BIT] = int_stat_r;
        rd_int_mask             = '0;
        rd_int_mask[EXPIRE_BIT] = int_mask_r;
    end

    // Read data mux; unmapped offsets read as zero
    always_comb begin
        dat_nxt = '0;
        if (hit_control) begin
            dat_nxt = rd_control;
        end else if (hit_status) begin
            dat_nxt = rd_status;
        end else if (hit_int_stat) begin
            dat_nxt = rd_int_stat;
        end else if (hit_int_mask) begin
            dat_nxt = rd_int_mask;
        end
    end

    // Capture read data with the acknowledge
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            dat_r <= '0;
        end else if (access && !WB_WE_IN) begin
            dat_r <= dat_nxt;
        end else begin
            dat_r <= '0;
        end
    end

    assign WB_DAT_OUT     = dat_r;
    assign WB_ACK_OUT     = ack_r;
    assign IRQ_OUT        = irq_r;
    assign WDT_EXPIRE_OUT = expire_r;
endmodule
`default_nettype wire

// *** wdt_timeout_ctrl_sva.sv ***
// Checker for the watchdog timeout control block, bound to its top ports.
// Assumes the bench runs one Wishbone request at a time on MCLK_IN.
`timescale 1ns/1ps
`default_nettype none
module wdt_timeout_ctrl_sva
    import wdt_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
    input wire logic                 MCLK_IN,
    input wire logic                 SYS_RST_IN,
    input wire logic                 WB_CYC_IN,
    input wire logic                 WB_STB_IN,
    input wire logic                 WB_WE_IN,
    input wire logic [ADR_W-1:0]     WB_ADR_IN,
    input wire logic [SEL_W-1:0]     WB_SEL_IN,
    input wire logic [DAT_W-1:0]     WB_DAT_IN,
    input wire logic [DAT_W-1:0]     WB_DAT_OUT,
    input wire logic                 WB_ACK_OUT,
    input wire logic                 IRQ_OUT,
    input wire logic                 WDT_EXPIRE_OUT
);
    logic              take;
    logic [TOUT_W-1:0] tout_r;
    logic              lock_r;
    logic              mask_r;
    logic              rd_r;
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    assign take = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    // Shadow of the control and mask fields as written over the bus
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            tout_r <= TOUT_RST;
            lock_r <= LOCK_RST;
            mask_r <= MASK_RST;
            rd_r   <= 1'b0;
        end else begin
            rd_r <= take && !WB_WE_IN && WB_ADR_IN == OFS_CONTROL;
            if (take && WB_WE_IN && WB_SEL_IN[0] && WB_ADR_IN == OFS_CONTROL) begin
                lock_r <= WB_DAT_IN[LOCK_BIT];
                if (!lock_r && !WB_DAT_IN[LOCK_BIT]) tout_r <= WB_DAT_IN[5:0];
            end
            if (take && WB_WE_IN && WB_SEL_IN[0] && WB_ADR_IN == OFS_INT_MASK)
                mask_r <= WB_DAT_IN[0];
        end
    end
    sequence s_take; WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT; endsequence
    sequence s_quiet; !WDT_EXPIRE_OUT [*7]; endsequence
    a_ack_latency: assert property (s_take |=> WB_ACK_OUT) else $error("late ack");
    a_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("long ack");
    a_data_idle: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == '0) else $error("idle data");
    a_strobe_zero: assert property (rd_r |-> !WB_DAT_OUT[STROBE_BIT])
        else $error("strobe read back");
    a_ctrl_readback: assert property (rd_r |-> WB_DAT_OUT[6:0] == {lock_r, tout_r})
        else $error("control readback");
    a_expire_gap: assert property (WDT_EXPIRE_OUT |=> s_quiet)
        else $error("expiry too soon");
    a_disabled_quiet: assert property (tout_r == '0 && $past(tout_r) == '0
        && $past(tout_r, 2) == '0 |-> !WDT_EXPIRE_OUT) else $error("expiry while disabled");
    a_irq_follow: assert property (WDT_EXPIRE_OUT && mask_r |=> IRQ_OUT) else $error("irq missing");
    a_irq_masked: assert property (!mask_r && !$past(mask_r) |-> !IRQ_OUT) else $error("masked irq");
endmodule
bind wdt_timeout_ctrl wdt_timeout_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES))
    i_wdt_timeout_ctrl_sva (.*);
`default_nettype wire

// *** test_wdt_timeout_ctrl.sv ***
// Self-checking bench for the watchdog timeout control block.
// Assumes a short tick divider so that whole intervals fit a short run.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t got %h expected %h", $time, a, b); end end
module test_wdt_timeout_ctrl;
    import wdt_pkg::*;
    localparam int TK = 8;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic        ack, irq, expo;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, dout, q, rnd = 32'hA957;
    logic [5:0]  tout_m = 6'h00;
    logic        lock_m = 1'b0;
    int          failures = 0, checked = 0, cycles = 0, n;
    int          tn[3] = '{1, 5, 63};
    always #4 clk = ~clk;
    wdt_timeout_ctrl #(.TICK_CYCLES(TK)) i_wdt_timeout_ctrl (.MCLK_IN(clk), .SYS_RST_IN(rst),
        .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
        .WB_DAT_IN(dat), .WB_DAT_OUT(dout), .WB_ACK_OUT(ack), .IRQ_OUT(irq),
        .WDT_EXPIRE_OUT(expo));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic end_sim();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
        do @(posedge clk); while (ack !== 1'b1);
        q = dout;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    // Write with the reference model of the control fields
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
        wb(1'b1, a, {24'h0, d}, s);
        if (a == OFS_CONTROL && s[0]) begin
            if (!lock_m && !d[6]) tout_m = d[5:0];
            lock_m = d[6];
        end
    endtask
    task automatic wait_exp();
        n = 0;
        do begin @(posedge clk); n++; end while (expo !== 1'b1 && n < 700);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin failures++; end_sim(); end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, OFS_CONTROL, 32'h0, 4'hF); `CHK(q, 32'h0)
        wb(1'b0, OFS_STATUS, 32'h0, 4'hF);  `CHK(q, 32'h0)
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            wr(OFS_CONTROL, rnd[7:0], rnd[11:8]);
            wb(1'b0, OFS_CONTROL, 32'h0, 4'hF);
            `CHK(q[7:0], {1'b0, lock_m, tout_m})
        end
        foreach (tn[i]) begin
            wr(OFS_CONTROL, 8'h00, 4'h1);
            wr(OFS_CONTROL, 8'h00, 4'h1);
            wr(OFS_CONTROL, tn[i][7:0], 4'h1);
            wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
            `CHK(q, {18'h0, tn[i][5:0], 8'h01})
            wait_exp(); `CHK(n >= tn[i] * TK - 1 && n <= tn[i] * TK + 4, 1'b1)
            wr(OFS_CONTROL, 8'hC0, 4'h1);
            wait_exp(); `CHK(n >= tn[i] * TK - 1 && n <= tn[i] * TK + 4, 1'b1)
            wb(1'b0, OFS_CONTROL, 32'h0, 4'hF);
            `CHK(q[7:0], {2'b01, tn[i][5:0]})
        end
        // Sticky expiry status and mask
        `CHK(irq, 1'b0)
        wb(1'b0, OFS_INT_STAT, 32'h0, 4'hF); `CHK(q[0], 1'b1)
        wr(OFS_INT_MASK, 8'h01, 4'h1);
        repeat (2) @(posedge clk); `CHK(irq, 1'b1)
        // Shortest interval with the interrupt unmasked
        wr(OFS_CONTROL, 8'h00, 4'h1);
        wr(OFS_CONTROL, 8'h01, 4'h1);
        wait_exp(); `CHK(n >= TK - 1 && n <= TK + 4, 1'b1)
        repeat (2) @(posedge clk); `CHK(irq, 1'b1)
        wr(OFS_CONTROL, 8'h00, 4'h1);
        wr(OFS_CONTROL, 8'h00, 4'h1);
        wr(OFS_INT_STAT, 8'h01, 4'h1);
        repeat (2) @(posedge clk); `CHK(irq, 1'b0)
        // Disabled watchdog stays silent
        n = 0;
        repeat (600) begin @(posedge clk); if (expo !== 1'b0) n++; end
        `CHK(n, 0)
        wb(1'b0, OFS_STATUS, 32'h0, 4'hF); `CHK(q, 32'h0)
        wb(1'b1, 8'h10, 32'hFF, 4'hF);
        wb(1'b0, 8'h10, 32'h0, 4'hF); `CHK(q, 32'h0)
        wb(1'b0, OFS_CONTROL, 32'h0, 4'hF); `CHK(q, 32'h0)
        end_sim();
    end
endmodule
`default_nettype wire
